// ===== rtl/jnp_port.sv
// test-port programming logic for on-chip nonvolatile memory
`include "jnp_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module jnp_port
  import jnp_pkg::*;
(
  // clocks and power-on reset
  input wire logic tck_i,
  input wire logic clock_i,
  input wire logic rst_i,
  // decoded test-port controller state, tck domain
  input wire logic [`JNP_IR_W-1:0] ir_i,
  input wire logic capture_dr_i,
  input wire logic shift_dr_i,
  input wire logic update_dr_i,
  input wire logic run_idle_i,
  input wire logic tdi_i,
  output logic tdo_o,
  // memory programming interface, tck domain
  output logic [`JNP_CMD_W-1:0] cmd_o,
  output logic cmd_apply_o,
  output logic cmd_exec_o,
  input wire logic [`JNP_CMD_W-1:0] result_i,
  // page buffer port, tck domain
  output logic page_wr_o,
  output logic page_rd_o,
  output logic [`JNP_PADDR_W-1:0] page_addr_o,
  output logic [`JNP_BYTE_W-1:0] page_wdata_o,
  input wire logic [`JNP_BYTE_W-1:0] page_rdata_i,
  // core side, clock_i domain
  input wire logic [1:0] tout_sel_i,
  output logic core_rst_o,
  output logic prog_mode_o
);

  // time-out length for a fuse selection
  function automatic logic [`JNP_TOUT_W-1:0] tout_limit(input logic [1:0] sel);
    logic [`JNP_TOUT_W-1:0] lim;
    lim = `JNP_TOUT_SEL0;
    unique case (sel)
      2'h0: lim = `JNP_TOUT_SEL0;
      2'h1: lim = `JNP_TOUT_SEL1;
      2'h2: lim = `JNP_TOUT_SEL2;
      2'h3: lim = `JNP_TOUT_SEL3;
    endcase
    return lim;
  endfunction : tout_limit

  // byte shift register, lsb first toward tdo
  function automatic logic [`JNP_BYTE_W-1:0] byte_shift(
    input logic [`JNP_BYTE_W-1:0] cur,
    input logic in_bit
  );
    return {in_bit, cur[`JNP_BYTE_W-1:1]};
  endfunction : byte_shift

  // ---------------------------------------------------------------
  // instruction decode, tck domain
  // ---------------------------------------------------------------
  logic sel_hold;
  logic sel_key;
  logic sel_cmd;
  logic sel_load;
  logic sel_read;

  assign sel_hold = (ir_i == `JNP_IR_CHIP_HOLD);
  assign sel_key = (ir_i == `JNP_IR_KEY_UNLOCK);
  assign sel_cmd = (ir_i == `JNP_IR_COMMAND_ENTRY);
  assign sel_load = (ir_i == `JNP_IR_PAGE_STREAM_IN);
  assign sel_read = (ir_i == `JNP_IR_PAGE_STREAM_OUT);

  // ---------------------------------------------------------------
  // single-bit reset chain
  // ---------------------------------------------------------------
  logic hold;

  // no update stage: the shifted bit acts at once
  always_ff @(posedge tck_i or posedge rst_i) begin
    if (rst_i) begin
      hold <= 1'b0;
    end else if (sel_hold && shift_dr_i) begin
      hold <= tdi_i;
    end
  end

  // ---------------------------------------------------------------
  // programming key and programming mode
  // ---------------------------------------------------------------
  logic [`JNP_KEY_W-1:0] key_sr;
  logic prog_mode;

  always_ff @(posedge tck_i or posedge rst_i) begin
    if (rst_i) begin
      key_sr <= `JNP_KEY_RESET;
    end else if (sel_key && shift_dr_i) begin
      key_sr <= {tdi_i, key_sr[`JNP_KEY_W-1:1]};
    end
  end

  // a wrong key at update also leaves programming mode
  always_ff @(posedge tck_i or posedge rst_i) begin
    if (rst_i) begin
      prog_mode <= 1'b0;
    end else if (sel_key && update_dr_i) begin
      prog_mode <= (key_sr == `JNP_KEY_VALUE);
    end
  end

  // ---------------------------------------------------------------
  // command register
  // ---------------------------------------------------------------
  logic [`JNP_CMD_W-1:0] cmd_sr;
  logic exec_armed;

  always_ff @(posedge tck_i or posedge rst_i) begin
    if (rst_i) begin
      cmd_sr <= `JNP_CMD_RESET;
    end else if (sel_cmd && capture_dr_i) begin
      cmd_sr <= result_i;
    end else if (sel_cmd && shift_dr_i) begin
      cmd_sr <= {tdi_i, cmd_sr[`JNP_CMD_W-1:1]};
    end
  end

  // commands never reach memory without a valid key
  always_ff @(posedge tck_i or posedge rst_i) begin
    if (rst_i) begin
      cmd_o <= `JNP_CMD_RESET;
      cmd_apply_o <= 1'b0;
    end else begin
      cmd_apply_o <= 1'b0;
      if (sel_cmd && update_dr_i && prog_mode) begin
        cmd_o <= cmd_sr;
        cmd_apply_o <= 1'b1;
      end
    end
  end

  // one execute pulse per update, however long idle lasts
  always_ff @(posedge tck_i or posedge rst_i) begin
    if (rst_i) begin
      exec_armed <= 1'b0;
      cmd_exec_o <= 1'b0;
    end else begin
      cmd_exec_o <= 1'b0;
      if (sel_cmd && update_dr_i) begin
        exec_armed <= prog_mode;
      end else if (run_idle_i && exec_armed) begin
        exec_armed <= 1'b0;
        cmd_exec_o <= prog_mode;
      end
    end
  end

  // ---------------------------------------------------------------
  // virtual page chains, built on one byte register
  // ---------------------------------------------------------------
  jnp_stream_t state;
  jnp_stream_t next_state;
  logic [`JNP_BYTE_W-1:0] byte_sr;
  logic [`JNP_BITCNT_W-1:0] bit_cnt;
  logic [`JNP_PADDR_W-1:0] byte_idx;
  logic byte_done;

  assign byte_done = (bit_cnt == `JNP_BITCNT_LAST);

  // chains start at capture; every scan ends at update
  always_comb begin
    next_state = state;
    unique case (state)
      jnp_st_idle: begin
        if (capture_dr_i && sel_load) begin
          next_state = jnp_st_load;
        end else if (capture_dr_i && sel_read) begin
          next_state = jnp_st_read;
        end
      end
      jnp_st_load: begin
        if (update_dr_i) begin
          next_state = jnp_st_idle;
        end
      end
      jnp_st_read: begin
        if (update_dr_i) begin
          next_state = jnp_st_idle;
        end
      end
      default: begin
        next_state = jnp_st_idle;
      end
    endcase
  end

  always_ff @(posedge tck_i or posedge rst_i) begin
    if (rst_i) begin
      state <= jnp_st_idle;
    end else begin
      state <= next_state;
    end
  end

  // byte framing counts from the first shifted bit, which only
  // holds when no other device sits ahead in the chain
  always_ff @(posedge tck_i or posedge rst_i) begin
    if (rst_i) begin
      bit_cnt <= '0;
      byte_idx <= '0;
    end else if (state == jnp_st_idle) begin
      bit_cnt <= '0;
      byte_idx <= '0;
    end else if (shift_dr_i) begin
      bit_cnt <= bit_cnt + 3'h1;
      if (byte_done) begin
        byte_idx <= byte_idx + 7'h01;
      end
    end
  end

  // read chain leads with one empty byte, hence page plus eight
  always_ff @(posedge tck_i or posedge rst_i) begin
    if (rst_i) begin
      byte_sr <= '0;
    end else if (state == jnp_st_idle) begin
      byte_sr <= '0;
    end else if (shift_dr_i && state == jnp_st_load) begin
      byte_sr <= byte_shift(byte_sr, tdi_i);
    end else if (shift_dr_i && state == jnp_st_read) begin
      if (byte_done) begin
        byte_sr <= prog_mode ? page_rdata_i : '0;
      end else begin
        byte_sr <= byte_shift(byte_sr, 1'b0);
      end
    end
  end

  // page buffer transfers happen at capture (first read) and inside shift, not at update
  always_ff @(posedge tck_i or posedge rst_i) begin
    if (rst_i) begin
      page_wr_o <= 1'b0;
      page_rd_o <= 1'b0;
      page_addr_o <= '0;
      page_wdata_o <= '0;
    end else begin
      page_wr_o <= 1'b0;
      page_rd_o <= 1'b0;
      if (state == jnp_st_idle && capture_dr_i && sel_read) begin
        page_rd_o <= prog_mode;
        page_addr_o <= '0;
      end else if (shift_dr_i && byte_done && state == jnp_st_load) begin
        page_wr_o <= prog_mode;
        page_addr_o <= byte_idx;
        page_wdata_o <= byte_shift(byte_sr, tdi_i);
      end else if (shift_dr_i && byte_done && state == jnp_st_read) begin
        page_rd_o <= prog_mode;
        page_addr_o <= byte_idx + 7'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // scan output
  // ---------------------------------------------------------------
  always_comb begin
    tdo_o = 1'b0;
    if (sel_hold) begin
      tdo_o = hold;
    end else if (sel_key) begin
      tdo_o = key_sr[0];
    end else if (sel_cmd) begin
      tdo_o = cmd_sr[0];
    end else if (sel_load || sel_read) begin
      tdo_o = byte_sr[0];
    end
  end

  // ---------------------------------------------------------------
  // core side, clock_i domain
  // ---------------------------------------------------------------
  logic hold_async;
  logic hold_meta;
  logic hold_sync;
  logic [1:0] sel_meta;
  logic [1:0] sel_sync;
  logic pm_meta;
  logic [`JNP_TOUT_W-1:0] tout_cnt;

  // assertion is asynchronous so the hold bites without delay
  assign hold_async = rst_i | hold;

  always_ff @(posedge clock_i or posedge hold_async) begin
    if (hold_async) begin
      hold_meta <= 1'b1;
      hold_sync <= 1'b1;
    end else begin
      hold_meta <= 1'b0;
      hold_sync <= hold_meta;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      sel_meta <= 2'h0;
      sel_sync <= 2'h0;
      pm_meta <= 1'b0;
      prog_mode_o <= 1'b0;
    end else begin
      sel_meta <= tout_sel_i;
      sel_sync <= sel_meta;
      pm_meta <= prog_mode;
      prog_mode_o <= pm_meta;
    end
  end

  // core stays reset for the selected time-out after release
  always_ff @(posedge clock_i or posedge hold_async) begin
    if (hold_async) begin
      tout_cnt <= '0;
      core_rst_o <= 1'b1;
    end else if (hold_sync) begin
      tout_cnt <= '0;
      core_rst_o <= 1'b1;
    end else if (tout_cnt >= tout_limit(sel_sync)) begin
      core_rst_o <= 1'b0;
    end else begin
      tout_cnt <= tout_cnt + 13'h0001;
    end
  end

endmodule : jnp_port
`default_nettype wire

// ===== include/jnp_regs.svh
// constants of the test-port programming logic
`ifndef JNP_REGS_SVH
`define JNP_REGS_SVH

// instruction register
`define JNP_IR_W 4
`define JNP_IR_CHIP_HOLD 4'hc
`define JNP_IR_KEY_UNLOCK 4'h4
`define JNP_IR_COMMAND_ENTRY 4'h5
`define JNP_IR_PAGE_STREAM_IN 4'h6
`define JNP_IR_PAGE_STREAM_OUT 4'h7

// programming key
`define JNP_KEY_W 16
`define JNP_KEY_VALUE 16'ha370
`define JNP_KEY_RESET 16'h0000

// command register
`define JNP_CMD_W 15
`define JNP_CMD_RESET 15'h0000

// virtual page chains
`define JNP_BYTE_W 8
`define JNP_BITCNT_W 3
`define JNP_BITCNT_LAST 3'h7
`define JNP_PADDR_W 7
`define JNP_PAGE_BYTES 128

// reset time-out, in clock_i cycles, per fuse selection
`define JNP_TOUT_W 13
`define JNP_TOUT_SEL0 13'h0001
`define JNP_TOUT_SEL1 13'h0010
`define JNP_TOUT_SEL2 13'h0100
`define JNP_TOUT_SEL3 13'h1000

`endif

// ===== include/jnp_pkg.sv
// types of the test-port programming logic
`default_nettype none
package jnp_pkg;
  typedef enum logic [2:0] {
    jnp_st_idle = 3'h1,
    jnp_st_load = 3'h2,
    jnp_st_read = 3'h4
  } jnp_stream_t;
endpackage : jnp_pkg
`default_nettype wire

// ===== tb/jnp_port_props.sv
// checker for the test-port programming logic
`timescale 1ns/1ps
`default_nettype none
module jnp_port_props (
  // watched ports
  input wire logic tck_i,
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [3:0] ir_i,
  input wire logic capture_dr_i,
  input wire logic shift_dr_i,
  input wire logic update_dr_i,
  input wire logic run_idle_i,
  input wire logic tdi_i,
  input wire logic tdo_o,
  input wire logic [14:0] cmd_o,
  input wire logic cmd_apply_o,
  input wire logic cmd_exec_o,
  input wire logic page_wr_o,
  input wire logic page_rd_o,
  input wire logic core_rst_o,
  input wire logic prog_mode_o
);
  default clocking @(posedge tck_i);
  endclocking
  default disable iff (rst_i);
  AST_APPLY_SRC: assert property (cmd_apply_o |-> $past(update_dr_i) && $past(ir_i) == 4'h5)
    else $error("apply without update");
  AST_APPLY_ONE: assert property (cmd_apply_o |=> !cmd_apply_o)
    else $error("apply too long");
  AST_CMD_HOLD: assert property ($changed(cmd_o) |-> cmd_apply_o)
    else $error("command moved");
  AST_EXEC_SRC: assert property (cmd_exec_o |-> $past(run_idle_i) && !$past(cmd_exec_o))
    else $error("bad execute");
  AST_WR_SRC: assert property (page_wr_o |-> $past(shift_dr_i) && $past(ir_i) == 4'h6)
    else $error("bad page write");
  AST_RD_SRC: assert property (page_rd_o |-> $past(capture_dr_i || shift_dr_i) && $past(ir_i) == 4'h7)
    else $error("bad page read");
  AST_HOLD_SET: assert property (ir_i == 4'hc && shift_dr_i && tdi_i |=> core_rst_o)
    else $error("hold late");
  AST_HOLD_TDO: assert property ((ir_i == 4'hc && shift_dr_i) ##1 ir_i == 4'hc |-> tdo_o == $past(tdi_i))
    else $error("hold chain out");
  AST_IDLE_TDO: assert property (ir_i < 4'h4 |-> !tdo_o)
    else $error("scan out driven");
  AST_RST_TOUT: assert property (@(posedge clock_i) $fell(core_rst_o) |-> $past(core_rst_o, 3))
    else $error("time-out short");
  COV_EXEC: cover property (cmd_exec_o);
  COV_WR: cover property (page_wr_o);
  COV_RD: cover property (page_rd_o);
  COV_PROG: cover property (@(posedge clock_i) $rose(prog_mode_o));
endmodule : jnp_port_props
bind jnp_port jnp_port_props jnp_port_props_inst (.tck_i, .clock_i, .rst_i, .ir_i, .capture_dr_i,
  .shift_dr_i, .update_dr_i, .run_idle_i, .tdi_i, .tdo_o, .cmd_o, .cmd_apply_o, .cmd_exec_o,
  .page_wr_o, .page_rd_o, .core_rst_o, .prog_mode_o);
`default_nettype wire

// ===== tb/jnp_programmer.sv
// programmer model: drives controller state and scan data
`timescale 1ns/1ps
`default_nettype none
module jnp_programmer (
  // link clock and scan return
  input wire logic tck_i,
  input wire logic tdo_i,
  // controller state toward the port
  output logic [3:0] ir_o,
  output logic capture_o,
  output logic shift_o,
  output logic update_o,
  output logic run_idle_o,
  output logic tdi_o
);
  initial {ir_o, capture_o, shift_o, update_o, run_idle_o, tdi_o} = 9'h0;
  // sole device on the chain, so page chains are allowed
  task automatic scan(input logic [3:0] ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    dout = 32'h0;
    @(negedge tck_i);
    ir_o = ir;
    capture_o = 1'b1;
    @(negedge tck_i);
    capture_o = 1'b0;
    for (int i = 0; i < n; i++) begin
      shift_o = 1'b1;
      tdi_o = din[i];
      dout[i] = tdo_i;
      @(negedge tck_i);
    end
    shift_o = 1'b0;
    // released data line must not look like held data
    tdi_o = ~tdi_o;
    update_o = 1'b1;
    @(negedge tck_i);
    update_o = 1'b0;
  endtask : scan
  task automatic idle(input int n);
    run_idle_o = 1'b1;
    repeat (n) @(negedge tck_i);
    run_idle_o = 1'b0;
  endtask : idle
endmodule : jnp_programmer
`default_nettype wire

// ===== tb/jnp_port_bench.sv
// self-checking bench for the test-port programming logic
`timescale 1ns/1ps
`default_nettype none
`include "jnp_regs.svh"
module jnp_port_bench;
  logic clock_i = 1'b0;
  logic tck_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] ir_i;
  logic capture_dr_i, shift_dr_i, update_dr_i, run_idle_i, tdi_i, tdo_o;
  logic [14:0] cmd_o, result_i;
  logic cmd_apply_o, cmd_exec_o, page_wr_o, page_rd_o, core_rst_o, prog_mode_o;
  logic [6:0] page_addr_o;
  logic [7:0] page_wdata_o;
  logic [7:0] page_rdata_i = 8'h0;
  logic [1:0] tout_sel_i = 2'h0;
  logic [7:0] mem [128] = '{default: 8'h5a};
  logic [31:0] got;
  int n_errors = 0;
  int compares = 0;
  int n_apply = 0;
  int n_exec = 0;
  int n_wr = 0;
  always #50 clock_i = ~clock_i;
  // offset start keeps the two clocks unrelated in phase
  initial begin
    #3.3;
    forever #6 tck_i = ~tck_i;
  end
  jnp_port jnp_port_inst (.tck_i, .clock_i, .rst_i, .ir_i, .capture_dr_i, .shift_dr_i,
    .update_dr_i, .run_idle_i, .tdi_i, .tdo_o, .cmd_o, .cmd_apply_o, .cmd_exec_o, .result_i,
    .page_wr_o, .page_rd_o, .page_addr_o, .page_wdata_o, .page_rdata_i, .tout_sel_i,
    .core_rst_o, .prog_mode_o);
  jnp_programmer jnp_programmer_inst (.tck_i(tck_i), .tdo_i(tdo_o), .ir_o(ir_i),
    .capture_o(capture_dr_i), .shift_o(shift_dr_i), .update_o(update_dr_i),
    .run_idle_o(run_idle_i), .tdi_o(tdi_i));
  // page buffer and pulse counters
  always @(posedge tck_i) begin
    if (page_wr_o) mem[page_addr_o] <= page_wdata_o;
    if (page_rd_o) page_rdata_i <= mem[page_addr_o];
    n_apply <= n_apply + int'(cmd_apply_o);
    n_exec <= n_exec + int'(cmd_exec_o);
    n_wr <= n_wr + int'(page_wr_o);
  end
  task automatic print_verdict;
    if (n_errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask : chk
  task automatic wait_core(input logic v, output int k);
    k = 0;
    while (core_rst_o !== v && k < 20000) begin
      @(negedge clock_i);
      k++;
    end
    if (core_rst_o !== v) begin
      n_errors++;
      $display("CHECK FAILED %0t core reset wait", $time);
      print_verdict();
    end
  endtask : wait_core
  task automatic t_reset;
    int k;
    repeat (4) @(negedge clock_i);
    chk(32'({core_rst_o, prog_mode_o, cmd_apply_o, page_wr_o}), 32'h8, "reset");
    @(negedge clock_i);
    rst_i = 1'b0;
    @(negedge clock_i);
    chk(32'(core_rst_o), 32'h1, "early run");
    wait_core(1'b0, k);
    // two sync edges plus the count, seen from the first low edge
    chk(32'(k), 32'(`JNP_TOUT_SEL0) + 32'h2, "reset time-out");
  endtask : t_reset
  task automatic t_hold(input logic v);
    int k;
    if (!v) begin
      tout_sel_i = 2'h1;
      repeat (3) @(negedge clock_i);
    end
    jnp_programmer_inst.scan(4'hc, 1, 32'(v), got);
    chk(got, 32'(!v), "hold out");
    chk(32'(core_rst_o), 32'h1, "hold");
    if (!v) begin
      wait_core(1'b0, k);
      // release edge is unrelated to clock_i, so one edge of slack
      chk(32'(k >= int'(`JNP_TOUT_SEL1) + 3 && k <= int'(`JNP_TOUT_SEL1) + 4), 32'h1,
          "hold time-out");
    end
  endtask : t_hold
  task automatic t_poll;
    int n;
    n = 0;
    result_i = 15'h0000;
    got = 32'h0;
    while (!got[9] && n < 8) begin
      if (n == 2) result_i = 15'h0200;
      jnp_programmer_inst.scan(4'h5, 15, 32'h3380, got);
      jnp_programmer_inst.idle(1);
      n++;
    end
    chk(32'(n), 32'h3, "poll count");
  endtask : t_poll
  task automatic t_key;
    jnp_programmer_inst.scan(4'h4, 16, 32'h1234, got);
    chk(got, 32'h0, "key reset");
    jnp_programmer_inst.scan(4'h5, 15, 32'h3380, got);
    jnp_programmer_inst.idle(3);
    chk(32'(n_apply + n_exec), 32'h0, "locked");
    repeat (4) @(negedge clock_i);
    chk(32'(prog_mode_o), 32'h0, "bad key");
    jnp_programmer_inst.scan(4'h4, 16, 32'b1010_0011_0111_0000, got);
    chk(got, 32'h1234, "key out");
    repeat (4) @(negedge clock_i);
    chk(32'(prog_mode_o), 32'h1, "key ok");
  endtask : t_key
  task automatic t_cmd;
    logic [14:0] w [10] = '{15'h2380, 15'h3180, 15'h3380, 15'h2310, 15'h07a5, 15'h133c,
                           15'h7700, 15'h2302, 15'h2311, 15'h2303};
    int a, e;
    foreach (w[i]) begin
      result_i = 15'h4000 | 15'(i);
      a = n_apply;
      e = n_exec;
      jnp_programmer_inst.scan(4'h5, 15, 32'(w[i]), got);
      jnp_programmer_inst.idle(3);
      chk(got, 32'h4000 | 32'(i), "result");
      chk(32'(cmd_o), 32'(w[i]), "command");
      chk(32'(n_apply - a), 32'h1, "apply");
      chk(32'(n_exec - e), 32'h1, "execute");
    end
  endtask : t_cmd
  task automatic t_page;
    jnp_programmer_inst.scan(4'h6, 16, 32'hbeef, got);
    chk(32'({mem[1], mem[0]}), 32'hbeef, "page in");
    jnp_programmer_inst.scan(4'h7, 24, 32'hffffff, got);
    chk(got, 32'h00beef00, "page out");
    chk(32'(n_wr), 32'h2, "writes");
  endtask : t_page
  initial begin
    result_i = 15'h0;
    t_reset();
    t_hold(1'b1);
    t_key();
    t_cmd();
    t_poll();
    t_page();
    t_hold(1'b0);
    print_verdict();
  end
endmodule : jnp_port_bench
`default_nettype wire
